// *** core/scsr_event_status.sv ***
// Purpose: sticky raw event bits, mask and masked status with write-one-to-clear
// Assumes: event inputs are already synchronised to CLK
// Notes:   a set arriving in the clear cycle wins
`timescale 1ns/1ps
`include "scsr_params.svh"
module scsr_event_status (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // event pulses or levels
  input  wire scsr_pkg::scsr_evt_t events,
  // software controls
  input  wire logic              mask_we,
  input  wire scsr_pkg::scsr_evt_t mask_wdata,
  input  wire logic              clr_we,
  input  wire scsr_pkg::scsr_evt_t clr_wdata,
  // state
  output scsr_pkg::scsr_evt_t     raw_r,
  output scsr_pkg::scsr_evt_t     mask_r,
  output scsr_pkg::scsr_evt_t     masked
);
  scsr_pkg::scsr_evt_t raw_nxt;
  scsr_pkg::scsr_evt_t clr_bits;

  // clearing a masked bit also clears its raw bit; unmasked bits ignore the clear
  assign clr_bits = clr_we ? (clr_wdata & mask_r & `SCSR_EVT_LIVE) : `SCSR_RESET_EVT;
  assign raw_nxt  = ((raw_r & ~clr_bits) | events) & `SCSR_EVT_LIVE;
  assign masked   = raw_r & mask_r;

  // raw bits and mask are flops; masked view is a gate
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      raw_r  <= `SCSR_RESET_EVT;
      mask_r <= `SCSR_RESET_EVT;
    end
    else
    begin
      raw_r <= raw_nxt;
      if (mask_we)
        mask_r <= mask_wdata & `SCSR_EVT_LIVE;
    end
  end
endmodule

// *** core/scsr_params.svh ***
// Purpose: offsets, field positions, reset values and widths of the status and reset-cause block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   raw status sits at 0x050, mask at 0x054, masked status at 0x058, cause at 0x05C
`ifndef SCSR_PARAMS_SVH
`define SCSR_PARAMS_SVH

`define SCSR_ADDR_W          12
`define SCSR_OFF_RAW         12'h050
`define SCSR_OFF_MASK        12'h054
`define SCSR_OFF_MASKED      12'h058
`define SCSR_OFF_CAUSE       12'h05C

`define SCSR_EVT_W           7
`define SCSR_EVT_LIVE        7'h7E
`define SCSR_EVT_PLL_LOCK    6
`define SCSR_EVT_CUR_LIMIT   5
`define SCSR_EVT_INT_OSC     4
`define SCSR_EVT_MAIN_OSC    3
`define SCSR_EVT_REG_LOSS    2
`define SCSR_EVT_BROWNOUT    1

`define SCSR_CAUSE_W         6
`define SCSR_CAUSE_REG_LOSS  5
`define SCSR_CAUSE_SOFTWARE  4
`define SCSR_CAUSE_WATCHDOG  3
`define SCSR_CAUSE_BROWNOUT  2
`define SCSR_CAUSE_POWER_ON  1
`define SCSR_CAUSE_EXTERNAL  0

`define SCSR_RESET_EVT       7'h00
`define SCSR_RESET_CAUSE     6'h00
`define SCSR_RDATA_ZERO      32'h0000_0000

`endif

// *** core/scsr_pkg.sv ***
// Purpose: shared types of the status and reset-cause block
// Assumes: scsr_params.svh sets the widths
// Notes:   bus request travels as one packed struct
`include "scsr_params.svh"
package scsr_pkg;
  typedef logic [`SCSR_EVT_W-1:0]   scsr_evt_t;
  typedef logic [`SCSR_CAUSE_W-1:0] scsr_cause_t;
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`SCSR_ADDR_W-1:0] addr;
    logic [31:0]             wdata;
  } scsr_req_t;
endpackage

// *** core/scsr_reset_cause.sv ***
// Purpose: reset-cause record, loaded from cause strobes that survive the system reset
// Assumes: this logic sits on the always-on reset, not the system reset
// Notes:   external reset wipes other causes, others accumulate
`timescale 1ns/1ps
`include "scsr_params.svh"
module scsr_reset_cause (
  // clock and power-on reset
  input  wire logic                  clk,
  input  wire logic                  por_b,
  // synchronised cause strobes
  input  wire scsr_pkg::scsr_cause_t cause_in,
  // software write
  input  wire logic                  we,
  input  wire scsr_pkg::scsr_cause_t wdata,
  // record
  output scsr_pkg::scsr_cause_t      cause_r
);
  scsr_pkg::scsr_cause_t cause_nxt;
  scsr_pkg::scsr_cause_t base;
  logic                  ext_hit;

  // software may overwrite; hardware sets win over the same-cycle write
  assign base      = we ? wdata : cause_r;
  assign ext_hit   = cause_in[`SCSR_CAUSE_EXTERNAL];
  // external reset keeps only its own bit; others are or-ed in
  assign cause_nxt = ext_hit ? (scsr_pkg::scsr_cause_t'(1) << `SCSR_CAUSE_EXTERNAL)
                             : (base | cause_in);

  // power-on is recorded on the first edge after the power-on release
  always_ff @(posedge clk or negedge por_b)
  begin
    if (!por_b)
      cause_r <= `SCSR_RESET_CAUSE;
    else
      cause_r <= cause_nxt;
  end
endmodule

// *** core/scsr_top.sv ***
// Purpose: system event status and reset-cause registers behind an APB slave
// Assumes: CLK 20 MHz; RST_B async active low is the always-on power-on reset
// Notes:   cause and event inputs are pins, double-flopped before use
//
// How it works
// - current-limit event sets raw status bit five
// - write one clears status bit, zero keeps
// - clearing masked bit also clears raw bit
// - masked bit is raw gated by mask
// - cause register loaded from reset sources
// - external reset sets bit zero, clears others
// - other causes set their bit and accumulate
// - regulator loss sets cause bit five
// - software reset sets cause bit four
// - watchdog reset sets cause bit three
// - brown-out reset sets cause bit two
// - power-on reset sets cause bit one
// - external reset pin sets cause bit zero
// - cause bits readable and writable by software
// - cause bits 31:6 read zero, ignore writes
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "scsr_params.svh"
module scsr_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // system event detectors
  input  wire logic        PLL_LOCK_EVT,
  input  wire logic        CUR_LIMIT_EVT,
  input  wire logic        INT_OSC_FAULT_EVT,
  input  wire logic        MAIN_OSC_FAULT_EVT,
  input  wire logic        REG_LOSS_EVT,
  input  wire logic        BROWNOUT_EVT,
  // reset source strobes
  input  wire logic        REG_LOSS_RST,
  input  wire logic        SOFTWARE_RST,
  input  wire logic        WATCHDOG_RST,
  input  wire logic        BROWNOUT_RST,
  input  wire logic        EXTERNAL_RST,
  // interrupt
  output logic             IRQ
);
  // synchroniser stages: raw pins into two flops
  scsr_pkg::scsr_evt_t   evt_pin;
  scsr_pkg::scsr_evt_t   evt_s1_r;
  scsr_pkg::scsr_evt_t   evt_s2_r;
  scsr_pkg::scsr_cause_t cause_pin;
  scsr_pkg::scsr_cause_t cause_s1_r;
  scsr_pkg::scsr_cause_t cause_s2_r;
  scsr_pkg::scsr_cause_t cause_evt;
  logic                  por_pend_r;
  scsr_pkg::scsr_req_t   req;
  logic                  hit_raw;
  logic                  hit_mask;
  logic                  hit_masked;
  logic                  hit_cause;
  logic                  hit_any;
  scsr_pkg::scsr_evt_t   raw_r;
  scsr_pkg::scsr_evt_t   mask_r;
  scsr_pkg::scsr_evt_t   masked;
  scsr_pkg::scsr_cause_t cause_r;
  logic [31:0]           rdata_nxt;
  logic [31:0]           prdata_r;

  // event pins gathered into their bit positions; bit 0 is never live
  assign evt_pin = {PLL_LOCK_EVT, CUR_LIMIT_EVT, INT_OSC_FAULT_EVT,
                    MAIN_OSC_FAULT_EVT, REG_LOSS_EVT, BROWNOUT_EVT, 1'b0};

  // cause pins in cause-bit order; power-on comes from the reset release below
  assign cause_pin = {REG_LOSS_RST,
                      SOFTWARE_RST,
                      WATCHDOG_RST,
                      BROWNOUT_RST,
                      1'b0,
                      EXTERNAL_RST};

  // two-flop synchronisers; only the second stage is read
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      evt_s1_r   <= `SCSR_RESET_EVT;
      evt_s2_r   <= `SCSR_RESET_EVT;
      cause_s1_r <= `SCSR_RESET_CAUSE;
      cause_s2_r <= `SCSR_RESET_CAUSE;
    end
    else
    begin
      evt_s1_r   <= evt_pin;
      evt_s2_r   <= evt_s1_r;
      cause_s1_r <= cause_pin;
      cause_s2_r <= cause_s1_r;
    end
  end

  // one pending flag marks the first edge after power-on release
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      por_pend_r <= 1'b1;
    else
      por_pend_r <= 1'b0;
  end

  // power-on is caught by a clocked process, never by the async reset itself
  assign cause_evt = cause_s2_r
                   | (por_pend_r ? (scsr_pkg::scsr_cause_t'(1) << `SCSR_CAUSE_POWER_ON)
                                 : `SCSR_RESET_CAUSE);

  // apb request: writes land in the access phase, zero wait states
  assign req.wr    = PSEL & PENABLE & PWRITE;
  assign req.rd    = PSEL & ~PENABLE & ~PWRITE;
  assign req.addr  = PADDR;
  assign req.wdata = PWDATA;

  // address decode; unmapped addresses answer with an error
  assign hit_raw    = (req.addr == `SCSR_OFF_RAW);
  assign hit_mask   = (req.addr == `SCSR_OFF_MASK);
  assign hit_masked = (req.addr == `SCSR_OFF_MASKED);
  assign hit_cause  = (req.addr == `SCSR_OFF_CAUSE);
  assign hit_any    = hit_raw | hit_mask | hit_masked | hit_cause;

  // sticky events, mask and write-one-to-clear status
  scsr_event_status u_evt (
    .clk        (CLK),
    .rst_b      (RST_B),
    .events     (evt_s2_r),
    .mask_we    (req.wr & hit_mask),
    .mask_wdata (req.wdata[`SCSR_EVT_W-1:0]),
    .clr_we     (req.wr & hit_masked),
    .clr_wdata  (req.wdata[`SCSR_EVT_W-1:0]),
    .raw_r      (raw_r),
    .mask_r     (mask_r),
    .masked     (masked)
  );

  // reset-cause record; upper write bits are dropped
  scsr_reset_cause u_cause (
    .clk      (CLK),
    .por_b    (RST_B),
    .cause_in (cause_evt),
    .we       (req.wr & hit_cause),
    .wdata    (req.wdata[`SCSR_CAUSE_W-1:0]),
    .cause_r  (cause_r)
  );

  // read mux; narrow registers zero-extend so reserved bits read zero
  assign rdata_nxt = hit_raw    ? {25'h000_0000, raw_r}     :
                     hit_mask   ? {25'h000_0000, mask_r}    :
                     hit_masked ? {25'h000_0000, masked}    :
                     hit_cause  ? {26'h000_0000, cause_r}   :
                     `SCSR_RDATA_ZERO;

  // read data captured in setup phase so it stands flopped in access phase
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      prdata_r <= `SCSR_RDATA_ZERO;
    else if (req.rd)
      prdata_r <= rdata_nxt;
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;

  // level interrupt while any masked status bit is set
  assign IRQ = |masked;
endmodule

// *** tb/scsr_top_chk.sv ***
// Purpose: port assertions for scsr_top
// Assumes: zero-wait apb, mask mirrored from bus writes
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module scsr_top_chk (
  // clock, reset and bus
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  // event and interrupt
  input wire logic        CUR_LIMIT_EVT,
  input wire logic        IRQ
);
  logic [6:0] m_r;
  // access-phase strobes
  wire acc  = PSEL && PENABLE;
  wire wr54 = acc && PWRITE && PADDR == 12'h054;
  wire wr58 = acc && PWRITE && PADDR == 12'h058;
  wire rd   = acc && !PWRITE;
  // mask mirror; bit 0 has no event behind it
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      m_r <= 7'h00;
    else if (wr54)
      m_r <= PWDATA[6:0] & 7'h7E;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_msk_rsv; rd && PADDR == 12'h058 |-> PRDATA[31:7] == 25'h0 && !PRDATA[0]; endproperty
  a_msk_rsv: assert property (p_msk_rsv) else $error("masked spare bits set");
  property p_cau_rsv; rd && PADDR == 12'h05C |-> PRDATA[31:6] == 26'h0; endproperty
  a_cau_rsv: assert property (p_cau_rsv) else $error("cause spare bits set");
  property p_gate; rd && PADDR == 12'h058 |-> (PRDATA[6:0] & ~m_r) == 7'h00; endproperty
  a_gate: assert property (p_gate) else $error("masked bit without mask");
  property p_mask_rd; rd && PADDR == 12'h054 |-> PRDATA == {25'h0, m_r}; endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback");
  property p_no_irq; m_r == 7'h00 |-> !IRQ; endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while all masked");
  property p_cl; CUR_LIMIT_EVT && m_r[5] |-> ##[1:4] IRQ; endproperty
  a_cl: assert property (p_cl) else $error("current limit no irq");
  property p_keep; wr58 && PWDATA[6:0] == 7'h00 && IRQ |=> IRQ; endproperty
  a_keep: assert property (p_keep) else $error("zero write cleared");
  property p_fall; $fell(IRQ) |-> $past(wr54) || $past(wr58); endproperty
  a_fall: assert property (p_fall) else $error("irq fell unprompted");
endmodule

bind scsr_top scsr_top_chk u_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .CUR_LIMIT_EVT(CUR_LIMIT_EVT), .IRQ(IRQ));

// *** tb/scsr_top_tb.sv ***
// Purpose: self-checking bench for scsr_top
// Assumes: zero-wait apb; pins reach registers three edges late
// Notes:   table rows first, then event and cause sequences
`timescale 1ns/1ps
module scsr_top_tb;
  typedef struct {logic w; logic [11:0] a; logic [31:0] v;} scsr_row_t;
  logic        CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic [5:0]  ev, cs;
  int          n_fail, n_compared, cyc;
  // reads carry the expected word, writes the data
  scsr_row_t   rows[13] = '{'{1'b0, 12'h05C, 32'h0000_0002}, '{1'b0, 12'h058, 32'h0000_0000},
    '{1'b0, 12'h050, 32'h0000_0000}, '{1'b1, 12'h05C, 32'hFFFF_FFFF},
    '{1'b0, 12'h05C, 32'h0000_003F}, '{1'b1, 12'h05C, 32'h0000_0000},
    '{1'b0, 12'h05C, 32'h0000_0000}, '{1'b1, 12'h054, 32'h0000_007E},
    '{1'b1, 12'h058, 32'hFFFF_FFFF}, '{1'b0, 12'h058, 32'h0000_0000},
    '{1'b1, 12'h100, 32'hFFFF_FFFF}, '{1'b0, 12'h100, 32'h0000_0000},
    '{1'b0, 12'h054, 32'h0000_007E}};
  scsr_top dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PLL_LOCK_EVT(ev[5]), .CUR_LIMIT_EVT(ev[4]), .INT_OSC_FAULT_EVT(ev[3]),
    .MAIN_OSC_FAULT_EVT(ev[2]), .REG_LOSS_EVT(ev[1]), .BROWNOUT_EVT(ev[0]),
    .REG_LOSS_RST(cs[5]), .SOFTWARE_RST(cs[4]), .WATCHDOG_RST(cs[3]),
    .BROWNOUT_RST(cs[2]), .EXTERNAL_RST(cs[0]), .IRQ(IRQ));
  task conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  // request held until pready is seen; releasing costs a cycle so no signal is driven twice
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int waits;
    waits = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
    begin
      waits++;
      @(posedge CLK);
    end
    q = PRDATA;
    err = PSLVERR;
    // the slave answers in the first access cycle; a wait state is a fault
    chk("waits", waits, 32'h0000_0000);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  // irq is sampled mid-cycle, away from the edge
  task irq_is(input logic e);
    @(negedge CLK);
    chk("irq", {31'h0, IRQ}, {31'h0, e});
    @(posedge CLK);
  endtask
  // one-cycle strobe on a cause or event pin, then room for the sync chain
  task pulse(input int k, input logic c);
    if (c)
      cs[k] <= 1'b1;
    else
      ev[k] <= 1'b1;
    @(posedge CLK);
    cs <= 6'h00;
    ev <= 6'h00;
    repeat (5) @(posedge CLK);
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // a hang counts as a failure
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA, ev, cs} = '0;
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    foreach (rows[r])
    begin
      apb(rows[r].w, rows[r].a, rows[r].v);
      chk("slverr", {31'h0, err}, {31'h0, rows[r].a == 12'h100});
      if (!rows[r].w)
        chk("rdata", q, rows[r].v);
    end
    for (int k = 0; k < 6; k++)
    begin
      pulse(k, 1'b0);
      irq_is(1'b1);
      apb(1'b1, 12'h058, 32'h0000_0000);
      apb(1'b0, 12'h058, 32'h0000_0000);
      chk("masked", q, 32'h1 << (k + 1));
      apb(1'b1, 12'h058, 32'hFFFF_FFFF);
      apb(1'b0, 12'h050, 32'h0000_0000);
      chk("raw", q, 32'h0000_0000);
      irq_is(1'b0);
    end
    // unmasked event stays raw only
    apb(1'b1, 12'h054, 32'h0000_0000);
    pulse(4, 1'b0);
    irq_is(1'b0);
    apb(1'b0, 12'h050, 32'h0000_0000);
    chk("raw", q, 32'h0000_0020);
    apb(1'b1, 12'h054, 32'h0000_0020);
    irq_is(1'b1);
    for (int k = 2; k < 6; k++)
    begin
      pulse(k, 1'b1);
      apb(1'b0, 12'h05C, 32'h0000_0000);
      chk("cause", q, (32'h1 << (k + 1)) - 32'h4);
    end
    pulse(0, 1'b1);
    apb(1'b0, 12'h05C, 32'h0000_0000);
    chk("cause", q, 32'h0000_0001);
    // second reset mid-run: record restarts from power-on, irq drops with the status
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    irq_is(1'b0);
    apb(1'b0, 12'h05C, 32'h0000_0000);
    chk("cause", q, 32'h0000_0002);
    conclude();
  end
endmodule
